// ### rtl/srw_pkg.sv
// Package: constants and carrier types for the supervisor reset watchdog
package srw_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int RESET_STRETCH_MS = 200;
    localparam int WDOG_TIMEOUT_MS = 1600;
    localparam int KICK_MIN_NS = 100;
    localparam int DEBOUNCE_NS = 1000;
    localparam int RESET_STRETCH_CYC = RESET_STRETCH_MS * (CLK_HZ / 1000);
    localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int KICK_MIN_CYC = (KICK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 32;

    typedef struct packed {
        logic reset_n;
        logic reset;
    } srw_reset_type;

    typedef enum logic [2:0] {
        RST_HOLD = 3'b001,
        RST_STRETCH = 3'b010,
        RST_RUN = 3'b100
    } srw_rst_state_type;
endpackage

// ### rtl/srw_supervisor.sv
// Supervisor: stretched reset, debounced manual reset, watchdog, power-fail warning
////////////////////////////////////////////////////////////////////////////////
module srw_supervisor #(
    parameter int STRETCH_CYC = srw_pkg::RESET_STRETCH_CYC,
    parameter int WDOG_CYC = srw_pkg::WDOG_TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = srw_pkg::DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supply_fail,
    input wire logic manual_reset_in_n,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_disable,
    input wire logic power_fail_sense,
    output logic reset_out_n,
    output logic reset_out,
    output logic watchdog_expired_n,
    output logic power_fail_warn_n
);
    localparam int W = srw_pkg::CNT_W;

    logic mr_stable_r;
    logic [W-1:0] deb_cnt_r;
    logic [W-1:0] stretch_cnt_r;
    logic [W-1:0] wd_cnt_r;
    logic kick_prev_r;
    logic kick_edge;
    logic reset_cause;
    srw_pkg::srw_rst_state_type state_r;
    srw_pkg::srw_reset_type rst_out_r;

    ////////////////////////////////////////////////////////////////////////////
    // Manual reset debounce: a new level must hold DEBOUNCE_CYC cycles
    // Any bounce restarts the count, so only a level held steady gets through
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mr_stable_r <= 1'b1;
            deb_cnt_r <= '0;
        end else if (manual_reset_in_n == mr_stable_r) begin
            deb_cnt_r <= '0;
        end else if (deb_cnt_r >= W'(DEBOUNCE_CYC - 1)) begin
            mr_stable_r <= manual_reset_in_n;
            deb_cnt_r <= '0;
        end else begin
            deb_cnt_r <= deb_cnt_r + W'(1);
        end
    end

    // Watchdog expiry is deliberately not a cause here
    assign reset_cause = supply_fail | ~mr_stable_r;

    ////////////////////////////////////////////////////////////////////////////
    // Reset generation with stretch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= srw_pkg::RST_HOLD;
            stretch_cnt_r <= '0;
        end else begin
            case (state_r)
                srw_pkg::RST_HOLD: begin
                    stretch_cnt_r <= '0;
                    if (!reset_cause) begin
                        state_r <= srw_pkg::RST_STRETCH;
                    end
                end
                srw_pkg::RST_STRETCH: begin
                    // A cause seen mid-stretch starts the full period again
                    if (reset_cause) begin
                        state_r <= srw_pkg::RST_HOLD;
                        stretch_cnt_r <= '0;
                    end else if (stretch_cnt_r >= W'(STRETCH_CYC - 1)) begin
                        state_r <= srw_pkg::RST_RUN;
                    end else begin
                        stretch_cnt_r <= stretch_cnt_r + W'(1);
                    end
                end
                srw_pkg::RST_RUN: begin
                    if (reset_cause) begin
                        state_r <= srw_pkg::RST_HOLD;
                    end
                end
                default: begin
                    state_r <= srw_pkg::RST_HOLD;
                end
            endcase
        end
    end

    // Outputs from one flop pair, so the complement never skews
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_out_r <= '{reset_n: 1'b0, reset: 1'b1};
        end else begin
            rst_out_r.reset_n <= (state_r == srw_pkg::RST_RUN) && !reset_cause;
            rst_out_r.reset <= !((state_r == srw_pkg::RST_RUN) && !reset_cause);
        end
    end
    assign reset_out_n = rst_out_r.reset_n;
    assign reset_out = rst_out_r.reset;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: synchronous input, so one sample per level suffices for a pulse
    assign kick_edge = watchdog_kick_in ^ kick_prev_r;

    // Cleared like an idle kick line, so leaving reset fakes no kick
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            kick_prev_r <= 1'b0;
        end else begin
            kick_prev_r <= watchdog_kick_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wd_cnt_r <= '0;
            watchdog_expired_n <= 1'b1;
        end else if (supply_fail) begin
            // Supply fail outranks disable, so a bad supply always shows
            wd_cnt_r <= '0;
            watchdog_expired_n <= 1'b0;
        end else if (watchdog_disable) begin
            wd_cnt_r <= '0;
            watchdog_expired_n <= 1'b1;
        end else if (kick_edge) begin
            wd_cnt_r <= '0;
            watchdog_expired_n <= 1'b1;
        end else if (wd_cnt_r >= W'(WDOG_CYC - 1)) begin
            watchdog_expired_n <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_r + W'(1);
            watchdog_expired_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-fail warning: separate flop, no shared reset or watchdog term
    // Reset value reads as a warning, the safe side until the first sample
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_fail_warn_n <= 1'b0;
        end else begin
            power_fail_warn_n <= power_fail_sense;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_reset_complement: assert property (@(posedge ref_clk) disable iff (rst)
        reset_out == !reset_out_n) else $error("reset outputs not complementary");
    a_supply_reset: assert property (@(posedge ref_clk) disable iff (rst)
        supply_fail |=> !reset_out_n) else $error("supply fail did not assert reset");
    a_manual_reset: assert property (@(posedge ref_clk) disable iff (rst)
        !mr_stable_r |=> !reset_out_n) else $error("manual reset did not assert reset");
    a_debounce_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(mr_stable_r) |-> $past(manual_reset_in_n) == 1'b0)
        else $error("debounced level changed without input");
    a_stretch_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(reset_out_n) |-> $past(state_r == srw_pkg::RST_RUN)
        && $past(stretch_cnt_r, 2) >= W'(STRETCH_CYC - 1))
        else $error("reset released before stretch elapsed");
    a_kick_restart: assert property (@(posedge ref_clk) disable iff (rst)
        (kick_edge && !supply_fail) |=> (wd_cnt_r == '0 && watchdog_expired_n))
        else $error("kick did not restart watchdog");
    a_wdog_expire: assert property (@(posedge ref_clk) disable iff (rst)
        (!supply_fail && !watchdog_disable && !kick_edge && wd_cnt_r >= W'(WDOG_CYC - 1))
        |=> !watchdog_expired_n) else $error("watchdog failed to expire");
    a_wdog_supply: assert property (@(posedge ref_clk) disable iff (rst)
        supply_fail |=> !watchdog_expired_n) else $error("expiry not low on supply fail");
    a_wdog_disable: assert property (@(posedge ref_clk) disable iff (rst)
        (watchdog_disable && !supply_fail) |=> watchdog_expired_n)
        else $error("expiry active while disabled");
    a_wdog_no_reset: assert property (@(posedge ref_clk) disable iff (rst)
        (reset_out_n && !supply_fail && mr_stable_r) |=> reset_out_n)
        else $error("watchdog asserted reset");
    a_power_warn: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> power_fail_warn_n == $past(power_fail_sense))
        else $error("power fail warning wrong");

    // Counters stop at their limits, so no wrap can fake a release or a kick
    a_stretch_bound: assert property (@(posedge ref_clk) disable iff (rst)
        stretch_cnt_r < W'(STRETCH_CYC)) else $error("stretch counter out of range");
    a_wdog_bound: assert property (@(posedge ref_clk) disable iff (rst)
        wd_cnt_r < W'(WDOG_CYC)) else $error("watchdog counter out of range");
    a_stretch_low: assert property (@(posedge ref_clk) disable iff (rst)
        (state_r != srw_pkg::RST_RUN) |=> !reset_out_n)
        else $error("reset released outside run state");
    a_debounce_steady: assert property (@(posedge ref_clk) disable iff (rst)
        (manual_reset_in_n == mr_stable_r) |=> $stable(mr_stable_r))
        else $error("debounced level moved without input change");
    a_warn_steady: assert property (@(posedge ref_clk) disable iff (rst)
        (!$past(rst) && $stable(power_fail_sense)) |=> $stable(power_fail_warn_n))
        else $error("power fail warning moved with steady sense");
    a_kick_any_edge: assert property (@(posedge ref_clk) disable iff (rst)
        (watchdog_kick_in != kick_prev_r && !supply_fail && !watchdog_disable)
        |=> watchdog_expired_n) else $error("single kick transition not taken");

    // Coverage of the main scenarios
    c_reset_release: cover property (@(posedge ref_clk) disable iff (rst) $rose(reset_out_n));
    c_wdog_expire: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(watchdog_expired_n) && !supply_fail);
    c_manual_press: cover property (@(posedge ref_clk) disable iff (rst) $fell(mr_stable_r));
    c_power_warn: cover property (@(posedge ref_clk) disable iff (rst) $fell(power_fail_warn_n));
    c_kick_restart: cover property (@(posedge ref_clk) disable iff (rst)
        kick_edge && wd_cnt_r != '0);
endmodule // srw_supervisor

// ### verification/srw_cpu_model.sv
// Partner model: supervised processor toggling its watchdog kick line
module srw_cpu_model #(
    parameter int PERIOD = 10
) (
    input wire logic ref_clk,
    input wire logic reset_out_n,
    input wire logic kick_en,
    output logic watchdog_kick_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic kick_r = 1'b0;
    assign watchdog_kick_in = kick_r;
    // A processor held in reset runs no code, so it never kicks then
    always @(posedge ref_clk) begin
        if (!reset_out_n || !kick_en) begin
            cnt <= 0;
        end else if (cnt == PERIOD - 1) begin
            cnt <= 0;
            kick_r <= ~kick_r;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // srw_cpu_model

// ### verification/testbench.sv
// Testbench: scenario tasks for the supervisor reset watchdog
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    localparam int WC = 50;
    localparam int DC = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_fail = 1'b0;
    logic manual_reset_in_n = 1'b1;
    logic watchdog_disable = 1'b0;
    logic power_fail_sense = 1'b1;
    logic kick_en = 1'b1;
    logic watchdog_kick_in, reset_out_n, reset_out, watchdog_expired_n, power_fail_warn_n;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    srw_supervisor #(.STRETCH_CYC(SC), .WDOG_CYC(WC), .DEBOUNCE_CYC(DC)) srw_supervisor_i (
        .ref_clk(ref_clk), .rst(rst), .supply_fail(supply_fail),
        .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(watchdog_kick_in),
        .watchdog_disable(watchdog_disable), .power_fail_sense(power_fail_sense),
        .reset_out_n(reset_out_n), .reset_out(reset_out),
        .watchdog_expired_n(watchdog_expired_n), .power_fail_warn_n(power_fail_warn_n));
    srw_cpu_model srw_cpu_model_i (.ref_clk(ref_clk), .reset_out_n(reset_out_n),
        .kick_en(kick_en), .watchdog_kick_in(watchdog_kick_in));
    initial forever #2.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_rst(input logic e);
        `CHK("reset_out_n", e, reset_out_n)
        `CHK("reset_out", ~e, reset_out)
    endtask
    task automatic t_supply();
        @(posedge ref_clk) supply_fail <= 1'b1;
        cyc(3);
        chk_rst(1'b0);
        `CHK("expired_n", 1'b0, watchdog_expired_n)
        `CHK("warn_n", 1'b1, power_fail_warn_n)
        @(posedge ref_clk) supply_fail <= 1'b0;
        cyc(SC - 2);
        chk_rst(1'b0);
        cyc(8);
        chk_rst(1'b1);
        $display("test supply done");
    endtask
    task automatic t_manual();
        @(posedge ref_clk) manual_reset_in_n <= 1'b0;
        cyc(DC - 3);
        @(posedge ref_clk) manual_reset_in_n <= 1'b1;
        cyc(DC + 4);
        chk_rst(1'b1);
        @(posedge ref_clk) manual_reset_in_n <= 1'b0;
        cyc(DC + 3);
        chk_rst(1'b0);
        @(posedge ref_clk) manual_reset_in_n <= 1'b1;
        cyc(SC - 2);
        chk_rst(1'b0);
        cyc(DC + 12);
        chk_rst(1'b1);
        $display("test manual done");
    endtask
    task automatic t_wdog();
        // Align to a kick: the count ran through the reset, so only a fresh kick fixes it
        @(watchdog_kick_in);
        @(posedge ref_clk) kick_en <= 1'b0;
        cyc(WC - 1);
        `CHK("expired_n", 1'b1, watchdog_expired_n)
        cyc(1);
        `CHK("expired_n", 1'b0, watchdog_expired_n)
        chk_rst(1'b1);
        @(posedge ref_clk) kick_en <= 1'b1;
        cyc(13);
        `CHK("expired_n", 1'b1, watchdog_expired_n)
        cyc(WC + 30);
        `CHK("expired_n", 1'b1, watchdog_expired_n)
        $display("test watchdog done");
    endtask
    task automatic t_disable();
        @(posedge ref_clk) watchdog_disable <= 1'b1;
        kick_en <= 1'b0;
        cyc(WC + 20);
        `CHK("expired_n", 1'b1, watchdog_expired_n)
        @(posedge ref_clk) watchdog_disable <= 1'b0;
        kick_en <= 1'b1;
        cyc(15);
        $display("test disable done");
    endtask
    task automatic t_pfw();
        @(posedge ref_clk) power_fail_sense <= 1'b0;
        cyc(2);
        `CHK("warn_n", 1'b0, power_fail_warn_n)
        chk_rst(1'b1);
        @(posedge ref_clk) power_fail_sense <= 1'b1;
        cyc(2);
        `CHK("warn_n", 1'b1, power_fail_warn_n)
        $display("test power fail done");
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Ceiling sits well above the roughly 360 cycles the scenarios need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        @(posedge ref_clk);
        @(posedge ref_clk) rst <= 1'b0;
        cyc(SC + 8);
        chk_rst(1'b1);
        t_supply();
        t_manual();
        t_wdog();
        t_disable();
        t_pfw();
        conclude();
    end
endmodule // testbench
